// >>> fio_cfg.svh
`ifndef FIO_CFG_SVH
`define FIO_CFG_SVH

// clock rate and timing figures in their own units
`define FIO_CLK_HZ        125000000
`define FIO_WDT_STEP_MS   100
`define FIO_WDT_SPAN_S    10
`define FIO_SUP_HOLD_MS   140

// bank layout
`define FIO_BANKS         4
`define FIO_BANK_W        16
`define FIO_FIELD_W       64
`define FIO_DEC_LINES     8

// watchdog monitor line: port 5 bit 8, bank index 2, bit 7, field line 39
`define FIO_WDT_BANK      2
`define FIO_WDT_BIT       7
`define FIO_WDT_LINE      39

// reset values
`define FIO_OUT_RESET     16'h0000
`define FIO_READ_IDLE     16'h0000

`endif

// >>> fio_dec_if.sv
`timescale 1ns/100ps
`default_nettype none

interface fio_dec_if;
   fio_pkg::fio_sel_t sel;
   logic              cs_n;
   logic              strobe_n;
   logic              en;
   logic [7:0]        line;

   modport src (output sel, output cs_n, output strobe_n, output en, input line);
   modport dec (input sel, input cs_n, input strobe_n, input en, output line);
endinterface

`default_nettype wire

// >>> fio_decoder.sv
`timescale 1ns/100ps
`default_nettype none

module fio_decoder (
   fio_dec_if.dec dif
);

   function automatic logic [7:0] fio_onehot(input fio_pkg::fio_sel_t s);
      fio_onehot = 8'h01 << s;
   endfunction

   always_comb begin
      if (!dif.cs_n && !dif.strobe_n && dif.en) begin
         dif.line = fio_onehot(dif.sel);
      end else begin
         dif.line = 8'h00;
      end
   end

endmodule

`default_nettype wire

// >>> fio_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module fio_host_model (
   input  wire logic        clk,
   input  wire logic        data_oe,
   input  wire logic [15:0] data_out,
   output var  logic        cs_n,
   output var  logic        oe_n,
   output var  logic        wr_n,
   output var  logic        enable,
   output var  logic [3:1]  addr,
   output var  logic [15:0] data_in
);
   initial begin
      cs_n = 1'b1;
      oe_n = 1'b1;
      wr_n = 1'b1;
      enable = 1'b0;
      addr = 3'h0;
      data_in = 16'h0000;
   end

   // released bus shows the inverse of its last word
   task automatic release_bus();
      cs_n = 1'b1;
      oe_n = 1'b1;
      wr_n = 1'b1;
      enable = 1'b0;
      data_in = ~data_in;
   endtask

   task automatic read_word(input logic [3:1] a, input logic en, output logic [15:0] d, output logic seen);
      int i;
      @(posedge clk);
      #1;
      addr = a;
      enable = en;
      cs_n = 1'b0;
      oe_n = 1'b0;
      seen = 1'b0;
      d = 16'h0000;
      for (i = 0; i < 4 && !seen; i++) begin
         @(posedge clk);
         if (data_oe === 1'b1) begin
            seen = 1'b1;
            d = data_out;
         end
      end
      #1;
      release_bus();
   endtask

   // word write; d2 replaces the data while the strobe is still low
   task automatic write_word(input logic [3:1] a, input logic [15:0] d, input logic [15:0] d2);
      @(posedge clk);
      #1;
      addr = a;
      enable = 1'b1;
      cs_n = 1'b0;
      wr_n = 1'b0;
      data_in = d;
      @(posedge clk);
      #1;
      data_in = d2;
      @(posedge clk);
      #1;
      release_bus();
   endtask
endmodule

`default_nettype wire

// >>> fio_pkg.sv
`default_nettype none

package fio_pkg;

   typedef logic [15:0] fio_word_t;
   typedef logic [2:0]  fio_sel_t;
   typedef logic [1:0]  fio_bank_t;

   typedef enum {
      FIO_WDT_IDLE,
      FIO_WDT_RUN
   } fio_wdt_e;

endpackage

`default_nettype wire

// >>> fio_ports.sv
`timescale 1ns/100ps
`default_nettype none
`include "fio_cfg.svh"

// Behaviour
// - jumper on: output 39 toggles, timed train
// - jumper off: no toggling on output 39
// - watchdog drives port five bit eight
// - supervisor holds reset 140ms after recovery
// - field reset ORs both requests
// - field inputs read ground-true, inverted
// - four 16-bit input banks, one word
// - input banks carry 1-16 through 49-64
// - input bank drives bus only when enabled
// - enables from gated three-to-eight decoder
// - written one sinks, zero leaves open
// - four 16-bit latched output banks
// - output banks drive 1-16 through 49-64
// - latch captures on strobe falling edge
// - separate decoder strobes one output bank

module fio_ports #(
   parameter int unsigned WDT_STEP_CYC = `FIO_WDT_STEP_MS * (`FIO_CLK_HZ / 1000),
   parameter int unsigned WDT_SPAN_CYC = `FIO_WDT_SPAN_S * `FIO_CLK_HZ,
   parameter int unsigned SUP_HOLD_CYC = `FIO_SUP_HOLD_MS * (`FIO_CLK_HZ / 1000)
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    bus_cs_n,
   input  wire logic                    bus_oe_n,
   input  wire logic                    bus_wr_n,
   input  wire logic                    bus_enable,
   input  wire logic [3:1]              bus_addr,
   input  wire logic [15:0]             bus_data_in,
   output var  logic [15:0]             bus_data_out,
   output var  logic                    bus_data_oe,
   input  wire logic [`FIO_FIELD_W-1:0] field_in_high,
   output var  logic [`FIO_FIELD_W-1:0] field_sink,
   input  wire logic                    wdt_jumper_on,
   input  wire logic                    wdt_start,
   output var  logic                    wdt_active,
   input  wire logic                    supply_ok,
   input  wire logic                    power_recovery_reset_n,
   input  wire logic                    software_reset_request,
   output var  logic                    supervisor_reset_n,
   output var  logic                    combined_field_reset,
   output var  logic                    processor_reset_line_n
);

   localparam logic [31:0] STEP_END = 32'(WDT_STEP_CYC - 1);
   localparam logic [31:0] SPAN_END = 32'(WDT_SPAN_CYC - 1);

   fio_dec_if rd_if ();
   fio_dec_if wr_if ();

   fio_pkg::fio_word_t out_bank [`FIO_BANKS];
   logic [7:0]         wr_line_q;
   logic [7:0]         wr_rise;
   fio_pkg::fio_wdt_e  wdt_state;
   logic [31:0]        wdt_step;
   logic [31:0]        wdt_span;
   logic               wdt_toggle;
   logic               rd_hit;

   function automatic fio_pkg::fio_word_t fio_sense(input logic [`FIO_FIELD_W-1:0] lv,
                                                   input fio_pkg::fio_bank_t b);
      fio_sense = ~lv[b*`FIO_BANK_W +: `FIO_BANK_W];
   endfunction

   assign rd_if.sel      = bus_addr;
   assign rd_if.cs_n     = bus_cs_n;
   assign rd_if.strobe_n = bus_oe_n;
   assign rd_if.en       = bus_enable;

   assign wr_if.sel      = bus_addr;
   assign wr_if.cs_n     = bus_cs_n;
   assign wr_if.strobe_n = bus_wr_n;
   assign wr_if.en       = bus_enable;

   fio_decoder u_rd_dec (
      .dif (rd_if.dec)
   );

   fio_decoder u_wr_dec (
      .dif (wr_if.dec)
   );

   fio_reset_ctl #(
      .HOLD_CYC (SUP_HOLD_CYC)
   ) u_reset (
      .clk                    (clk),
      .rst                    (rst),
      .supply_ok              (supply_ok),
      .power_recovery_reset_n (power_recovery_reset_n),
      .software_reset_request (software_reset_request),
      .supervisor_reset_n     (supervisor_reset_n),
      .combined_field_reset   (combined_field_reset),
      .processor_reset_line_n (processor_reset_line_n)
   );

   // input banks only on the low four decode lines
   assign rd_hit = |rd_if.line[3:0];

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_data_oe <= 1'b0;
      end else begin
         bus_data_oe <= rd_hit;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_data_out <= `FIO_READ_IDLE;
      end else if (rd_hit) begin
         bus_data_out <= fio_sense(field_in_high, bus_addr[2:1]);
      end else begin
         bus_data_out <= `FIO_READ_IDLE;
      end
   end

   // strobe history for edge detection
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_line_q <= 8'h00;
      end else begin
         wr_line_q <= wr_if.line;
      end
   end

   assign wr_rise = wr_if.line & ~wr_line_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int b = 0; b < `FIO_BANKS; b++) begin
            out_bank[b] <= `FIO_OUT_RESET;
         end
      end else begin
         for (int b = 0; b < `FIO_BANKS; b++) begin
            if (wr_rise[b]) begin
               out_bank[b] <= bus_data_in;
            end
         end
      end
   end

   // jumper off stops and clears train
   always_ff @(posedge clk) begin
      if (rst || !wdt_jumper_on) begin
         wdt_state  <= fio_pkg::FIO_WDT_IDLE;
         wdt_step   <= 32'h00000000;
         wdt_span   <= 32'h00000000;
         wdt_toggle <= 1'b0;
      end else begin
         unique case (wdt_state)
            fio_pkg::FIO_WDT_IDLE: begin
               wdt_step <= 32'h00000000;
               wdt_span <= 32'h00000000;
               if (wdt_start) begin
                  wdt_state <= fio_pkg::FIO_WDT_RUN;
               end
            end
            fio_pkg::FIO_WDT_RUN: begin
               if (wdt_step == STEP_END) begin
                  wdt_step   <= 32'h00000000;
                  wdt_toggle <= ~wdt_toggle;
               end else begin
                  wdt_step <= wdt_step + 32'h00000001;
               end
               if (wdt_span == SPAN_END) begin
                  wdt_state <= fio_pkg::FIO_WDT_IDLE;
               end else begin
                  wdt_span <= wdt_span + 32'h00000001;
               end
            end
         endcase
      end
   end

   assign wdt_active = (wdt_state == fio_pkg::FIO_WDT_RUN);

   // banks map to field lines in order
   // watchdog on port five bit eight
   always_ff @(posedge clk) begin
      if (rst) begin
         field_sink <= '0;
      end else begin
         for (int b = 0; b < `FIO_BANKS; b++) begin
            field_sink[b*`FIO_BANK_W +: `FIO_BANK_W] <= out_bank[b];
         end
         field_sink[`FIO_WDT_LINE] <= out_bank[`FIO_WDT_BANK][`FIO_WDT_BIT] ^ (wdt_jumper_on & wdt_toggle);
      end
   end

   latch_capture_a: assert property (@(posedge clk) disable iff (rst)
      wr_rise[1] |=> out_bank[1] == $past(bus_data_in)) else $error("bank did not capture on strobe edge");

   latch_hold_a: assert property (@(posedge clk) disable iff (rst)
      wr_rise[3:0] == 4'h0 |=> $stable(out_bank[0]) && $stable(out_bank[3]))
      else $error("bank changed without strobe edge");

   one_strobe_a: assert property (@(posedge clk) disable iff (rst)
      $onehot0(wr_rise)) else $error("more than one bank strobed");

   read_sense_a: assert property (@(posedge clk) disable iff (rst)
      rd_hit && bus_addr == 3'h2 |=> bus_data_oe && bus_data_out == ~$past(field_in_high[47:32]))
      else $error("bank three read wrong sense or lines");

   read_release_a: assert property (@(posedge clk) disable iff (rst)
      (bus_cs_n || bus_oe_n || !bus_enable || bus_addr[3]) |=> !bus_data_oe)
      else $error("bus driven without enable");

   sink_map_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> field_sink[63:48] == $past(out_bank[3]) && field_sink[15:0] == $past(out_bank[0]))
      else $error("output bank mapped to wrong lines");

   wdt_off_a: assert property (@(posedge clk) disable iff (rst)
      !wdt_jumper_on ##1 !wdt_jumper_on |-> field_sink[39] == $past(out_bank[2][7]))
      else $error("watchdog toggle with jumper off");

   wdt_step_a: assert property (@(posedge clk) disable iff (rst)
      $changed(wdt_toggle) && $past(wdt_jumper_on) |-> $past(wdt_step) == STEP_END)
      else $error("watchdog toggled off step boundary");

   wdt_span_a: assert property (@(posedge clk) disable iff (rst)
      wdt_active && wdt_span == SPAN_END && wdt_jumper_on |=> !wdt_active)
      else $error("watchdog train did not end");

   clear_open_a: assert property (@(posedge clk)
      $past(rst) |-> field_sink == '0 && out_bank[2] == `FIO_OUT_RESET)
      else $error("outputs not open after reset");

   capture_one_a: assert property (@(posedge clk) disable iff (rst)
      wr_rise[0] |=> out_bank[0] == $past(bus_data_in))
      else $error("bank one did not capture on strobe edge");

   capture_three_a: assert property (@(posedge clk) disable iff (rst)
      wr_rise[2] |=> out_bank[2] == $past(bus_data_in))
      else $error("bank three did not capture on strobe edge");

   capture_four_a: assert property (@(posedge clk) disable iff (rst)
      wr_rise[3] |=> out_bank[3] == $past(bus_data_in))
      else $error("bank four did not capture on strobe edge");

   read_one_a: assert property (@(posedge clk) disable iff (rst)
      rd_hit && bus_addr == 3'h0 |=> bus_data_out == ~$past(field_in_high[15:0]))
      else $error("bank one read wrong lines");

   read_two_a: assert property (@(posedge clk) disable iff (rst)
      rd_hit && bus_addr == 3'h1 |=> bus_data_out == ~$past(field_in_high[31:16]))
      else $error("bank two read wrong lines");

   read_four_a: assert property (@(posedge clk) disable iff (rst)
      rd_hit && bus_addr == 3'h3 |=> bus_data_out == ~$past(field_in_high[63:48]))
      else $error("bank four read wrong lines");

   read_idle_a: assert property (@(posedge clk) disable iff (rst)
      !rd_hit |=> bus_data_out == `FIO_READ_IDLE)
      else $error("read data not idle outside a read");

   read_drive_a: assert property (@(posedge clk) disable iff (rst)
      rd_hit |=> bus_data_oe)
      else $error("enabled bank did not drive the bus");

   sink_two_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> field_sink[31:16] == $past(out_bank[1]))
      else $error("bank two mapped to wrong lines");

   sink_three_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> field_sink[38:32] == $past(out_bank[2][6:0]) && field_sink[47:40] == $past(out_bank[2][15:8]))
      else $error("bank three mapped to wrong lines");

   wdt_line_a: assert property (@(posedge clk) disable iff (rst)
      wdt_jumper_on |=> field_sink[39] == ($past(out_bank[2][7]) ^ $past(wdt_toggle)))
      else $error("watchdog not on its monitor line");

   wdt_start_a: assert property (@(posedge clk) disable iff (rst)
      !wdt_active && wdt_start && wdt_jumper_on |=> wdt_active)
      else $error("watchdog train did not start");

   wdt_idle_a: assert property (@(posedge clk) disable iff (rst)
      !wdt_active && !wdt_start |=> !wdt_active)
      else $error("watchdog train started without request");

   wdt_abort_a: assert property (@(posedge clk) disable iff (rst)
      !wdt_jumper_on |=> !wdt_active && !wdt_toggle)
      else $error("watchdog train kept running with jumper off");

   write_gate_a: assert property (@(posedge clk) disable iff (rst)
      (bus_cs_n || bus_wr_n || !bus_enable) |-> wr_if.line == 8'h00)
      else $error("write strobe decoded without its gates");

   write_upper_a: assert property (@(posedge clk) disable iff (rst)
      bus_addr[3] |-> wr_rise[3:0] == 4'h0)
      else $error("unmapped address strobed a bank");

   clear_banks_a: assert property (@(posedge clk)
      $past(rst) |-> out_bank[0] == `FIO_OUT_RESET && out_bank[1] == `FIO_OUT_RESET
                     && out_bank[3] == `FIO_OUT_RESET)
      else $error("bank latches not open after reset");

endmodule

`default_nettype wire

// >>> fio_ports_bench.sv
`timescale 1ns/100ps
`default_nettype none

module fio_ports_bench;
   logic        clk;
   logic        rst;
   logic        cs_n;
   logic        oe_n;
   logic        wr_n;
   logic        enable;
   logic [3:1]  addr;
   logic [15:0] data_in;
   logic [15:0] data_out;
   logic        data_oe;
   logic [63:0] field_in_high;
   logic [63:0] field_sink;
   logic        jumper;
   logic        wdt_start;
   logic        wdt_active;
   logic        supply_ok;
   logic        pwr_n;
   logic        sw_req;
   logic        sup_n;
   logic        comb;
   logic        proc_n;
   int          bad_count;
   int          n_compared;

   fio_ports #(.WDT_STEP_CYC(8), .WDT_SPAN_CYC(80), .SUP_HOLD_CYC(10)) i_fio_ports (
      .clk(clk), .rst(rst), .bus_cs_n(cs_n), .bus_oe_n(oe_n), .bus_wr_n(wr_n), .bus_enable(enable),
      .bus_addr(addr), .bus_data_in(data_in), .bus_data_out(data_out), .bus_data_oe(data_oe),
      .field_in_high(field_in_high), .field_sink(field_sink), .wdt_jumper_on(jumper),
      .wdt_start(wdt_start), .wdt_active(wdt_active), .supply_ok(supply_ok),
      .power_recovery_reset_n(pwr_n), .software_reset_request(sw_req),
      .supervisor_reset_n(sup_n), .combined_field_reset(comb), .processor_reset_line_n(proc_n));

   fio_host_model i_fio_host_model (
      .clk(clk), .data_oe(data_oe), .data_out(data_out), .cs_n(cs_n), .oe_n(oe_n), .wr_n(wr_n),
      .enable(enable), .addr(addr), .data_in(data_in));

   always #4 clk = ~clk;

   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_sup(output int n);
      for (n = 0; n < 40 && sup_n !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      if (n == 40) begin
         bad_count++;
         tally_and_finish();
      end
   endtask

   task automatic t_supervisor();
      int n;
      check("sink after reset", 64'h0, field_sink);
      wait_sup(n);
      check("hold after reset", 1, n >= 9 && n <= 12);
      supply_ok = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("low on drop", 0, sup_n);
      supply_ok = 1'b1;
      wait_sup(n);
      check("hold after recovery", 1, n >= 9 && n <= 12);
   endtask

   task automatic t_reset_combo();
      for (int i = 0; i < 4; i++) begin
         pwr_n = i[0]; // supply request as a plain level
         sw_req = i[1];
         repeat (3) @(posedge clk);
         #1;
         check("combined reset", !i[0] | i[1], comb);
         check("processor reset", !(!i[0] | i[1]), proc_n);
      end
      pwr_n = 1'b1;
      sw_req = 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic t_reads();
      logic [15:0] d;
      logic        seen;
      field_in_high = 64'h0123_4567_89AB_CDEF;
      for (int b = 0; b < 4; b++) begin
         i_fio_host_model.read_word(b[2:0], 1'b1, d, seen);
         if (seen !== 1'b1) begin
            bad_count++;
            tally_and_finish();
         end
         check("input bank", 16'(~field_in_high[16*b+:16]), d);
      end
      for (int a = 4; a < 9; a++) begin
         i_fio_host_model.read_word(a[2:0] & 3'h7, a < 8, d, seen);
         check("refused read", 0, seen);
      end
   endtask

   task automatic t_writes();
      logic [15:0] w [4];
      logic [63:0] exp;
      w = '{16'h1234, 16'hA5C3, 16'h0080, 16'hFFFF};
      for (int b = 0; b < 4; b++) begin
         i_fio_host_model.write_word(b[2:0], w[b], w[b]);
         exp[16*b+:16] = w[b];
      end
      check("output banks", exp, field_sink);
      i_fio_host_model.write_word(3'h1, 16'h5A5A, 16'hFFFF);
      exp[31:16] = 16'h5A5A;
      @(posedge clk);
      #1;
      check("held strobe", exp, field_sink);
   endtask

   task automatic t_watchdog();
      int toggles;
      int first;
      int second;
      logic prev;
      logic was_active;
      logic [38:0] low;
      i_fio_host_model.write_word(3'h2, 16'h0000, 16'h0000);
      jumper = 1'b1;
      low = field_sink[38:0];
      for (int pass = 0; pass < 2; pass++) begin
         toggles = 0;
         first = 0;
         second = 0;
         was_active = 1'b0;
         prev = field_sink[39];
         wdt_start = 1'b1;
         @(posedge clk);
         #1;
         wdt_start = 1'b0;
         for (int c = 0; c < 100; c++) begin
            @(posedge clk);
            #1;
            was_active |= wdt_active;
            if (field_sink[39] !== prev) begin
               toggles++;
               second = (toggles == 2) ? c : second;
               first = (toggles == 1) ? c : first;
            end
            prev = field_sink[39];
         end
         if (pass == 0) begin
            check("train active", 1, was_active);
            check("toggle spacing", 8, second - first);
            check("toggle count", 1, toggles >= 9 && toggles <= 10);
            check("train ends", 0, wdt_active);
            check("other lines", low, field_sink[38:0]);
            jumper = 1'b0;
         end else begin
            check("jumper off", 0, toggles);
         end
      end
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      field_in_high = 64'h0;
      jumper = 1'b0;
      wdt_start = 1'b0;
      supply_ok = 1'b1;
      pwr_n = 1'b1;
      sw_req = 1'b0;
      bad_count = 0;
      n_compared = 0;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      t_supervisor();
      t_reset_combo();
      t_reads();
      t_writes();
      t_watchdog();
      tally_and_finish();
   end
endmodule

`default_nettype wire

// >>> fio_reset_ctl.sv
`timescale 1ns/100ps
`default_nettype none
`include "fio_cfg.svh"

module fio_reset_ctl #(
   parameter int unsigned HOLD_CYC = `FIO_SUP_HOLD_MS * (`FIO_CLK_HZ / 1000)
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic supply_ok,
   input  wire logic power_recovery_reset_n,
   input  wire logic software_reset_request,
   output var  logic supervisor_reset_n,
   output var  logic combined_field_reset,
   output var  logic processor_reset_line_n
);

   localparam logic [31:0] HOLD_LOAD = 32'(HOLD_CYC);

   logic [31:0] hold_cnt;
   logic        next_sup_low;

   always_ff @(posedge clk) begin
      if (rst || !supply_ok) begin
         hold_cnt <= HOLD_LOAD;
      end else if (hold_cnt != 32'h00000000) begin
         hold_cnt <= hold_cnt - 32'h00000001;
      end
   end

   assign next_sup_low = !supply_ok || (hold_cnt != 32'h00000000);

   always_ff @(posedge clk) begin
      if (rst) begin
         supervisor_reset_n <= 1'b0;
      end else begin
         supervisor_reset_n <= !next_sup_low;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         combined_field_reset   <= 1'b0;
         processor_reset_line_n <= 1'b0;
      end else begin
         combined_field_reset   <= !power_recovery_reset_n || software_reset_request;
         processor_reset_line_n <= !(!power_recovery_reset_n || software_reset_request || next_sup_low);
      end
   end

   sup_low_a: assert property (@(posedge clk) disable iff (rst)
      !supply_ok |=> !supervisor_reset_n [*2]) else $error("supervisor reset released during low supply");

   sup_hold_a: assert property (@(posedge clk) disable iff (rst)
      $rose(supervisor_reset_n) |-> $past(hold_cnt) == 32'h00000000 && $past(supply_ok))
      else $error("supervisor reset released before hold ended");

   combine_a: assert property (@(posedge clk) disable iff (rst)
      (!power_recovery_reset_n || software_reset_request) |=> combined_field_reset && !processor_reset_line_n)
      else $error("combined reset not asserted");

endmodule

`default_nettype wire
